// file: src/gate_drive_regs.svh
// named constants of the three-phase gate drive logic
// assumes inclusion by its bare name from the package and the design modules
// Overview of operation
// - high gate is inverse of high command
// - low gate is inverse of low command
// - one active-low fault for trip or lockout
// - both commands on holds both gates off
// - trip rising edge kills gates, asserts fault
// - trip fault latched until trip ends and all low released
// - short command gaps stretched to dead time
// - long command gaps pass unchanged
// - same dead time both directions, all channels
// - equal latency on every gate, on and off
// - logic supply low disables all, asserts fault
// - floating supply low disables high gates only
// - gates stay off until supplies are good
// - logic supply fault releases when supply recovers
// - high gate waits for new command edge after reset or floating supply low
`ifndef GATE_DRIVE_REGS_SVH
`define GATE_DRIVE_REGS_SVH
`define CLK_PERIOD_NS 4
`define DEAD_TIME_NS  500
`define DEAD_CYCLES   ((`DEAD_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEAD_CNT_W    8
`define PINS_RESET    11'h3ff
`define GATES_OFF     3'h0
`define LOW_RELEASED  3'h7
`endif

// file: src/gate_drive_pkg.sv
// types shared by the gate drive modules
// assumes gate_drive_regs.svh is on the include path
`include "gate_drive_regs.svh"
package gate_drive_pkg;
   // every pin input, gathered for the synchroniser
   typedef struct packed {
      logic       trip;
      logic       logic_low;
      logic [2:0] float_low;
      logic [2:0] high_side_cmd_n;
      logic [2:0] low_side_cmd_n;
   } pins_t;
   // over-current fault latch
   typedef enum logic {
      OC_CLEAR,
      OC_TRIPPED
   } oc_state_t;
endpackage

// file: src/gate_drive_channel.sv
// one half-bridge: interlock, dead time and high-side re-arm
// assumes synchronised active-high requests on the same clock
`timescale 1ns/100ps
`default_nettype none
`include "gate_drive_regs.svh"
module gate_drive_channel
   import gate_drive_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic hi_req,
   input  wire logic lo_req,
   input  wire logic kill_all,
   input  wire logic float_low,
   output logic      hi_on,
   output logic      lo_on
);
   localparam logic [`DEAD_CNT_W-1:0] DEAD = `DEAD_CNT_W'(`DEAD_CYCLES);
   localparam int DEAD_I = `DEAD_CYCLES;

   logic [`DEAD_CNT_W-1:0] dead_cnt;
   logic [`DEAD_CNT_W-1:0] next_dead_cnt;
   logic                   last_hi;
   logic                   next_last_hi;
   logic                   hi_block;
   logic                   next_hi_block;
   logic                   hi_req_d;
   logic                   next_hi_on;
   logic                   next_lo_on;
   logic                   want_hi;
   logic                   want_lo;
   logic                   gap_done;
   logic                   hi_edge;

   // next gate states; one register stage gives equal on and off latency
   always_comb begin
      want_hi       = hi_req & ~lo_req;
      want_lo       = lo_req & ~hi_req;
      hi_edge       = hi_req & ~hi_req_d;
      gap_done      = (dead_cnt >= DEAD);
      next_hi_block = float_low | (hi_block & ~hi_edge);
      next_hi_on    = want_hi & ~kill_all & ~float_low & ~next_hi_block & ~lo_on
                      & (hi_on | last_hi | gap_done);
      next_lo_on    = want_lo & ~kill_all & ~hi_on
                      & (lo_on | ~last_hi | gap_done);
      next_last_hi  = hi_on ? 1'b1 : (lo_on ? 1'b0 : last_hi);
      if (hi_on | lo_on) begin
         next_dead_cnt = `DEAD_CNT_W'(1);
      end else if (gap_done) begin
         next_dead_cnt = dead_cnt;
      end else begin
         next_dead_cnt = dead_cnt + `DEAD_CNT_W'(1);
      end
   end

   // gate and dead time registers; high side starts blocked until re-armed
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hi_on    <= 1'b0;
         lo_on    <= 1'b0;
         last_hi  <= 1'b0;
         hi_block <= 1'b1;
         hi_req_d <= 1'b0;
         dead_cnt <= DEAD;
      end else begin
         hi_on    <= next_hi_on;
         lo_on    <= next_lo_on;
         last_hi  <= next_last_hi;
         hi_block <= next_hi_block;
         hi_req_d <= hi_req;
         dead_cnt <= next_dead_cnt;
      end
   end

   // helper: cycles with both gates off, saturating
   logic [`DEAD_CNT_W-1:0] off_run;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         off_run <= '1;
      end else if (hi_on | lo_on) begin
         off_run <= '0;
      end else if (off_run != '1) begin
         off_run <= off_run + `DEAD_CNT_W'(1);
      end
   end

   a_no_shoot_through: assert property (
      @(posedge clk) disable iff (!rst_n) !(hi_on && lo_on))
      else $error("both gates of a channel on");
   a_dead_hi_to_lo: assert property (
      @(posedge clk) disable iff (!rst_n) $rose(lo_on) && last_hi |-> off_run >= DEAD_I)
      else $error("low gate on before dead time");
   a_dead_lo_to_hi: assert property (
      @(posedge clk) disable iff (!rst_n) $rose(hi_on) && !last_hi |-> off_run >= DEAD_I)
      else $error("high gate on before dead time");
   a_long_gap_pass: assert property (
      @(posedge clk) disable iff (!rst_n)
      want_lo && !kill_all && !hi_on && off_run >= DEAD_I |=> lo_on)
      else $error("long gap delayed further");
   a_float_low_high: assert property (
      @(posedge clk) disable iff (!rst_n) float_low |=> !hi_on)
      else $error("high gate on during floating supply low");
   a_float_low_keeps: assert property (
      @(posedge clk) disable iff (!rst_n)
      float_low && lo_on && want_lo && !kill_all |=> lo_on)
      else $error("low gate dropped by floating supply low");
   a_rearm_needs_edge: assert property (
      @(posedge clk) disable iff (!rst_n) hi_block && !hi_edge |=> !hi_on)
      else $error("high gate on without new command edge");
endmodule
`default_nettype wire

// file: src/three_phase_gate_drive.sv
// top of the three-phase gate drive logic: pin sync, fault latch, channels
// assumes pin levels from comparators and a controller, all asynchronous
`timescale 1ns/100ps
`default_nettype none
`include "gate_drive_regs.svh"
module three_phase_gate_drive
   import gate_drive_pkg::*;
(
   input  wire logic       SYS_CLK,
   input  wire logic       RST_N,
   input  wire logic [2:0] HIGH_SIDE_CMD_N,
   input  wire logic [2:0] LOW_SIDE_CMD_N,
   input  wire logic       OVERCURRENT_TRIP_IN,
   input  wire logic       LOGIC_SUPPLY_LOW,
   input  wire logic [2:0] FLOAT_SUPPLY_LOW,
   output logic [2:0]      HIGH_GATE_OUT,
   output logic [2:0]      LOW_GATE_OUT,
   output logic            FAULT_N_O,
   output logic            FAULT_N_OE
);
   pins_t     pins_raw;
   pins_t     pins_s1;
   pins_t     pins_s2;
   logic      trip_d;
   logic      trip_rise;
   logic      all_lo_released;
   logic      kill_all;
   oc_state_t oc_state;
   oc_state_t next_oc_state;
   logic      next_fault_oe;
   logic [2:0] hi_on;
   logic [2:0] lo_on;

   // gather the pins into one carrier
   always_comb begin
      pins_raw.trip            = OVERCURRENT_TRIP_IN;
      pins_raw.logic_low       = LOGIC_SUPPLY_LOW;
      pins_raw.float_low       = FLOAT_SUPPLY_LOW;
      pins_raw.high_side_cmd_n = HIGH_SIDE_CMD_N;
      pins_raw.low_side_cmd_n  = LOW_SIDE_CMD_N;
   end

   // two-stage synchroniser; reset assumes supplies low and commands off
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         pins_s1 <= `PINS_RESET;
         pins_s2 <= `PINS_RESET;
      end else begin
         pins_s1 <= pins_raw;
         pins_s2 <= pins_s1;
      end
   end

   // the second stage only ever takes the first stage, one edge later
   a_sync_chain: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) pins_s2 == $past(pins_s1))
      else $error("synchroniser stage skipped");
   a_sync_entry: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) $past(RST_N) |-> pins_s1 == $past(pins_raw))
      else $error("synchroniser first stage skipped");

   // trip edge, release condition and the fault latch next state
   always_comb begin
      trip_rise       = pins_s2.trip & ~trip_d;
      all_lo_released = (pins_s2.low_side_cmd_n == `LOW_RELEASED);
      next_oc_state   = oc_state;
      case (oc_state)
         OC_CLEAR: begin
            if (trip_rise) begin
               next_oc_state = OC_TRIPPED;
            end
         end
         OC_TRIPPED: begin
            if (!pins_s2.trip && all_lo_released && !trip_rise) begin
               next_oc_state = OC_CLEAR;
            end
         end
         default: begin
            next_oc_state = OC_TRIPPED;
         end
      endcase
      kill_all      = trip_rise | (oc_state == OC_TRIPPED) | pins_s2.logic_low;
      next_fault_oe = (next_oc_state == OC_TRIPPED) | pins_s2.logic_low;
   end

   // fault latch and open-drain fault pin; the pin only ever pulls low
   always_ff @(posedge SYS_CLK or negedge RST_N) begin
      if (!RST_N) begin
         trip_d     <= 1'b0;
         oc_state   <= OC_CLEAR;
         FAULT_N_O  <= 1'b0;
         FAULT_N_OE <= 1'b1;
      end else begin
         trip_d     <= pins_s2.trip;
         oc_state   <= next_oc_state;
         FAULT_N_O  <= 1'b0;
         FAULT_N_OE <= next_fault_oe;
      end
   end

   // fault latch: set on the trip edge, held while the trip or a low command stands
   a_trip_set: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) trip_rise |=> oc_state == OC_TRIPPED)
      else $error("trip edge did not latch the fault");
   a_clear_stays: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      oc_state == OC_CLEAR && !trip_rise |=> oc_state == OC_CLEAR)
      else $error("fault latched without trip edge");
   a_trip_holds: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      oc_state == OC_TRIPPED && pins_s2.trip |=> oc_state == OC_TRIPPED)
      else $error("trip fault released while trip stands");
   a_trip_clear: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      oc_state == OC_TRIPPED && !pins_s2.trip && all_lo_released |=> oc_state == OC_CLEAR)
      else $error("trip fault kept after all low commands released");
   a_trip_gates_off: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      oc_state == OC_TRIPPED |=> HIGH_GATE_OUT == `GATES_OFF && LOW_GATE_OUT == `GATES_OFF)
      else $error("gate on while trip fault latched");
   a_trip_oe: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) oc_state == OC_TRIPPED |-> FAULT_N_OE)
      else $error("trip fault latched but not shown");
   a_fault_rise_cause: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      $rose(FAULT_N_OE) |-> $past(trip_rise) || $past(pins_s2.logic_low))
      else $error("fault raised without trip edge or supply low");
   a_fault_data_low: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) FAULT_N_O == 1'b0)
      else $error("fault pin data not low");

   // one identical channel per half-bridge, so delays match
   for (genvar ch = 0; ch < 3; ch++) begin : g_chan
      gate_drive_channel u_chan (
         .clk       (SYS_CLK),
         .rst_n     (RST_N),
         .hi_req    (~pins_s2.high_side_cmd_n[ch]),
         .lo_req    (~pins_s2.low_side_cmd_n[ch]),
         .kill_all  (kill_all),
         .float_low (pins_s2.float_low[ch]),
         .hi_on     (hi_on[ch]),
         .lo_on     (lo_on[ch])
      );

      a_high_follows: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $rose(HIGH_GATE_OUT[ch]) |-> $past(!HIGH_SIDE_CMD_N[ch], 3))
         else $error("high gate on without command");
      a_low_follows: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $rose(LOW_GATE_OUT[ch]) |-> $past(!LOW_SIDE_CMD_N[ch], 3))
         else $error("low gate on without command");
      a_off_latency: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $fell(LOW_GATE_OUT[ch]) && !$past(kill_all)
         |-> $past(LOW_SIDE_CMD_N[ch] || !HIGH_SIDE_CMD_N[ch], 3))
         else $error("low gate off without command");

      // rises need a clean supply and no kill; falls follow the commands
      a_high_off_latency: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $fell(HIGH_GATE_OUT[ch]) && !$past(kill_all) && !$past(pins_s2.float_low[ch])
         |-> $past(HIGH_SIDE_CMD_N[ch] || !LOW_SIDE_CMD_N[ch], 3))
         else $error("high gate off without command");
      a_high_needs_supply: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $rose(HIGH_GATE_OUT[ch]) |-> !$past(pins_s2.float_low[ch]))
         else $error("high gate on during floating supply low");
      a_low_needs_logic: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $rose(LOW_GATE_OUT[ch]) |-> !$past(kill_all))
         else $error("low gate on while gates are killed");
      a_kill_high_off: assert property (
         @(posedge SYS_CLK) disable iff (!RST_N)
         $past(kill_all) |-> !HIGH_GATE_OUT[ch])
         else $error("high gate on while gates are killed");
   end

   // gate outputs come straight from the channel flip-flops
   always_comb begin
      HIGH_GATE_OUT = hi_on;
      LOW_GATE_OUT  = lo_on;
   end

   a_trip_kills: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      trip_rise |=> HIGH_GATE_OUT == `GATES_OFF && LOW_GATE_OUT == `GATES_OFF && FAULT_N_OE)
      else $error("trip did not kill gates and flag fault");
   a_trip_latched: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      oc_state == OC_TRIPPED && !all_lo_released |=> oc_state == OC_TRIPPED ##0 FAULT_N_OE)
      else $error("trip fault released early");
   a_logic_low_off: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      pins_s2.logic_low [*2] |-> HIGH_GATE_OUT == `GATES_OFF && LOW_GATE_OUT == `GATES_OFF
      && FAULT_N_OE)
      else $error("logic supply low did not disable gates");
   a_lockout_release: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      !pins_s2.logic_low && oc_state == OC_CLEAR && !trip_rise |=> !FAULT_N_OE)
      else $error("logic supply fault held after recovery");
   a_fault_source: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      FAULT_N_OE |-> $past(pins_s2.logic_low) || oc_state == OC_TRIPPED)
      else $error("fault flagged without cause");

   // logic supply lockout: gates off and fault shown, never latched
   a_logic_low_fault: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N) pins_s2.logic_low |=> FAULT_N_OE)
      else $error("logic supply low without fault");
   a_logic_low_kill: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      pins_s2.logic_low |=> HIGH_GATE_OUT == `GATES_OFF && LOW_GATE_OUT == `GATES_OFF)
      else $error("gate on during logic supply low");
   a_fault_released: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      !$past(pins_s2.logic_low) && oc_state == OC_CLEAR |-> !FAULT_N_OE)
      else $error("fault shown with supply good and no trip");
   a_power_up_off: assert property (
      @(posedge SYS_CLK) disable iff (!RST_N)
      !$past(RST_N) |-> HIGH_GATE_OUT == `GATES_OFF && LOW_GATE_OUT == `GATES_OFF
      && FAULT_N_OE)
      else $error("gate on or fault released straight after reset");
endmodule
`default_nettype wire

// file: verification/gate_switch_model.sv
// controller pins and power switches facing the gate drive logic
// assumes bench requests are active high and change just after a clock edge
`timescale 1ns/100ps
`default_nettype none
module gate_switch_model (
   input  wire logic       clk,
   input  wire logic [2:0] hi_req,
   input  wire logic [2:0] lo_req,
   input  wire logic [2:0] hi_gate,
   input  wire logic [2:0] lo_gate,
   input  wire logic       fault_oe,
   input  wire logic       fault_o,
   output logic [2:0]      hi_cmd_n,
   output logic [2:0]      lo_cmd_n,
   output logic            fault_n,
   output logic            shoot
);
   // controller drives active-low commands; releasing all lows once the trip ends clears a trip
   assign hi_cmd_n = ~hi_req;
   assign lo_cmd_n = ~lo_req;
   // open-drain fault wire with pull-up: shows the driven data only while enabled
   assign fault_n = fault_oe ? fault_o : 1'b1;
   // both switches of one leg conducting is remembered
   always @(posedge clk) begin
      if ((hi_gate & lo_gate) != 3'h0) shoot <= 1'b1;
      else if (shoot !== 1'b1) shoot <= 1'b0;
   end
endmodule
`default_nettype wire

// file: verification/test_three_phase_gate_drive.sv
// self-checking bench for the three-phase gate drive logic
// assumes the switch model file is compiled first
`timescale 1ns/100ps
`default_nettype none
`include "gate_drive_regs.svh"
module test_three_phase_gate_drive;
   import gate_drive_pkg::*;
   logic sys_clk, rst_n, trip, logic_low, oe, fo, fault_n, shoot;
   logic [2:0] hi_req, lo_req, hcmd, lcmd, float_low, hg, lg, bm;
   int fail_count, checked, ch, g, d;
   int gaps[8] = '{0, 0, 124, 125, 126, 3, 200, 1};
   three_phase_gate_drive DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .HIGH_SIDE_CMD_N(hcmd),
      .LOW_SIDE_CMD_N(lcmd), .OVERCURRENT_TRIP_IN(trip), .LOGIC_SUPPLY_LOW(logic_low),
      .FLOAT_SUPPLY_LOW(float_low), .HIGH_GATE_OUT(hg), .LOW_GATE_OUT(lg),
      .FAULT_N_O(fo), .FAULT_N_OE(oe));
   gate_switch_model partner (.clk(sys_clk), .hi_req(hi_req), .lo_req(lo_req), .hi_gate(hg),
      .lo_gate(lg), .fault_oe(oe), .fault_o(fo), .hi_cmd_n(hcmd), .lo_cmd_n(lcmd),
      .fault_n(fault_n), .shoot(shoot));
   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   // turn-on moment of the complementary gate after a command gap
   function automatic int dead_wait(input int gap);
      return (gap < `DEAD_CYCLES) ? 3 + `DEAD_CYCLES - gap : 3;
   endfunction
   task automatic drv(input logic [2:0] h, input logic [2:0] l);
      @(posedge sys_clk);
      hi_req <= h;
      lo_req <= l;
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [2:0] eh, input logic [2:0] el, input logic ef);
      checked = checked + 3;
      if (hg !== eh) begin
         fail_count++;
         $display("wrong value high gates expected %h seen %h", eh, hg);
      end
      if (lg !== el) begin
         fail_count++;
         $display("wrong value low gates expected %h seen %h", el, lg);
      end
      if (fault_n !== ef) begin
         fail_count++;
         $display("wrong value fault expected %h seen %h", ef, fault_n);
      end
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #400000;
      fail_count++;
      results();
   end
   // main sequence
   initial begin
      fail_count = 0;
      checked = 0;
      rst_n = 1'b0;
      trip = 1'b0;
      logic_low = 1'b1;
      float_low = 3'h7;
      hi_req = 3'h0;
      lo_req = 3'h0;
      void'($urandom(93161));
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      drv(3'h7, 3'h0);
      wt(5);
      chk(3'h0, 3'h0, 1'b0);
      @(posedge sys_clk);
      logic_low <= 1'b0;
      float_low <= 3'h0;
      wt(8);
      chk(3'h0, 3'h0, 1'b1);
      drv(3'h0, 3'h0);
      wt(3);
      drv(3'h7, 3'h0);
      wt(2);
      chk(3'h0, 3'h0, 1'b1);
      wt(1);
      chk(3'h7, 3'h0, 1'b1);
      drv(3'h0, 3'h0);
      wt(2);
      chk(3'h7, 3'h0, 1'b1);
      wt(1);
      chk(3'h0, 3'h0, 1'b1);
      wt(200);
      // complementary hand-over with gaps around the dead time
      for (int i = 0; i < 8; i++) begin
         ch = (i < 2) ? i : $urandom % 3;
         g = (i == 7) ? $urandom % 250 : gaps[i];
         bm = 3'h1 << ch;
         d = dead_wait(g);
         drv(i[0] ? bm : 3'h0, i[0] ? 3'h0 : bm);
         wt(200);
         if (g == 0) drv(i[0] ? 3'h0 : bm, i[0] ? bm : 3'h0);
         else begin
            drv(3'h0, 3'h0);
            repeat (g - 1) @(posedge sys_clk);
            drv(i[0] ? 3'h0 : bm, i[0] ? bm : 3'h0);
         end
         wt(d - 1);
         chk(3'h0, 3'h0, 1'b1);
         wt(1);
         chk(i[0] ? 3'h0 : bm, i[0] ? bm : 3'h0, 1'b1);
         drv(3'h0, 3'h0);
         wt(200);
      end
      drv(3'h7, 3'h7);
      wt(5);
      chk(3'h0, 3'h0, 1'b1);
      drv(3'h7, 3'h0);
      wt(200);
      @(posedge sys_clk) float_low <= 3'h2;
      wt(3);
      chk(3'h5, 3'h0, 1'b1);
      @(posedge sys_clk) float_low <= 3'h0;
      wt(6);
      chk(3'h5, 3'h0, 1'b1);
      drv(3'h5, 3'h0);
      wt(2);
      drv(3'h7, 3'h0);
      wt(3);
      chk(3'h7, 3'h0, 1'b1);
      drv(3'h0, 3'h1);
      wt(200);
      @(posedge sys_clk) float_low <= 3'h1;
      wt(3);
      chk(3'h0, 3'h1, 1'b1);
      @(posedge sys_clk) float_low <= 3'h0;
      wt(2);
      @(posedge sys_clk) trip <= 1'b1;
      wt(3);
      chk(3'h0, 3'h0, 1'b0);
      @(posedge sys_clk) trip <= 1'b0;
      wt(8);
      chk(3'h0, 3'h0, 1'b0);
      drv(3'h0, 3'h0);
      wt(6);
      chk(3'h0, 3'h0, 1'b1);
      drv(3'h0, 3'h1);
      wt(200);
      @(posedge sys_clk) logic_low <= 1'b1;
      wt(3);
      chk(3'h0, 3'h0, 1'b0);
      @(posedge sys_clk) logic_low <= 1'b0;
      wt(6);
      chk(3'h0, 3'h1, 1'b1);
      checked++;
      if (shoot !== 1'b0) begin
         fail_count++;
         $display("wrong value shoot expected 0 seen %b", shoot);
      end
      results();
   end
endmodule
`default_nettype wire
